// ===== inc/fsl_pkg.sv
package fsl_pkg;
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int SCR_N = 8;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_ACC_NS = 110;
  localparam int T_ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LAT_CYC = 3;
  localparam int T_RP_NS = 500;
  localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_GAP_MS = 5;
  localparam int RESUME_GAP_CYC = (RESUME_GAP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_GAP_US = 2;
  localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus addresses and command codes
  localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 25'h0000555;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 25'h00002AA;
  localparam logic [ADDR_W-1:0] ADR_ZERO = 25'h0000000;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_ERASE_SUSPEND = 16'h00B0;
  localparam logic [DATA_W-1:0] CMD_ERASE_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_LOCK_ENTRY = 16'h0040;
  localparam logic [DATA_W-1:0] CMD_PW_ENTRY = 16'h0060;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT2 = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_START = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_COUNT = 16'h0003;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_ABORT_RESET = 16'h00F0;

  // Lock register field positions
  localparam int LOCK_SECURED_BIT = 0;
  localparam int LOCK_PERSIST_BIT = 1;
  localparam int LOCK_PASSWORD_BIT = 2;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_WRITE = 4'h1, OP_SUSPEND = 4'h2, OP_RESUME = 4'h3,
    OP_LOCK_ENTER = 4'h4, OP_LOCK_PROG = 4'h5, OP_LOCK_READ = 4'h6,
    OP_PW_ENTER = 4'h7, OP_PW_PROG = 4'h8, OP_PW_READ = 4'h9,
    OP_PW_UNLOCK = 4'hA, OP_EXIT = 4'hB, OP_ABORT_RESET = 4'hC, OP_HW_RESET = 4'hD
  } fsl_op_type;

  typedef enum logic [1:0] {
    MODE_ARRAY = 2'h0, MODE_LOCKSET = 2'h1, MODE_PWSET = 2'h2
  } fsl_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_RST = 3'b100
  } fsl_state_type;

  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001, CY_SETUP = 4'b0010, CY_STROBE = 4'b0100, CY_HOLD = 4'b1000
  } fsl_cyc_state_type;
endpackage

// ===== src/fsl_cycle.sv
module fsl_cycle
  import fsl_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Cycle request
  input wire logic start_in,
  input wire logic rd_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  // Flash pins
  input wire logic [DATA_W-1:0] dq_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out
);
  fsl_cyc_state_type state_r;
  logic rd_r;
  logic [7:0] cnt_r;
  logic [DATA_W-1:0] s1_r, s2_r, s3_r, stable_r;

  localparam logic [7:0] WP_LEN = 8'(T_WP_CYC);
  localparam logic [7:0] RD_LEN = 8'(T_ACC_CYC + SYNC_LAT_CYC);

  // Data bus synchroniser, a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stable_r <= '0;
    end else begin
      s1_r <= dq_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        stable_r <= s3_r;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= CY_IDLE;
      cnt_r <= '0;
      rd_r <= 1'b0;
      addr_out <= '0;
      dq_out <= '0;
      rdata_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        CY_IDLE: begin
          if (start_in) begin
            rd_r <= rd_in;
            addr_out <= addr_in;
            dq_out <= wdata_in;
            state_r <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          cnt_r <= rd_r ? RD_LEN : WP_LEN;
          state_r <= CY_STROBE;
        end
        CY_STROBE: begin
          if (cnt_r == 8'h01) begin
            if (rd_r) begin
              rdata_out <= stable_r;
            end
            state_r <= CY_HOLD;
          end
          cnt_r <= cnt_r - 8'h01;
        end
        CY_HOLD: begin
          done_out <= 1'b1;
          state_r <= CY_IDLE;
        end
        default: state_r <= CY_IDLE;
      endcase
    end
  end

  assign ce_n_out = (state_r == CY_IDLE);
  assign oe_n_out = !(rd_r && (state_r == CY_STROBE));
  assign we_n_out = !(!rd_r && (state_r == CY_STROBE));
  assign dq_oe_out = !rd_r && (state_r != CY_IDLE);
endmodule

// ===== src/fsl_host.sv
// Contract
// R1 - Device takes erase suspend only while sector erase or its load window runs.
// R2 - Device ignores suspend during chip erase or word program.
// R3 - Device halts active sector erase within 20 us after suspend.
// R4 - Suspend during load window ends window at once, no erasure.
// R5 - Suspended device reads and programs unselected sectors only.
// R6 - Reads inside suspended sectors return status bits.
// R7 - Program during suspension reports status, then returns to suspended read.
// R8 - Suspended device accepts identification query sequence.
// R9 - Resume carries the suspended sector address; repeat resumes are ignored.
// R10 - Host waits at least 5 ms from resume to next suspend. The host accepts a suspend in the cycle of the resume's DONE_OUT pulse.
// R11 - Lock register holds three one-time bits, readable after access delay.
// R12 - Lock set blocks array access until its exit command.
// R13 - Unexited lock set hangs device until hardware reset.
// R14 - Lock program setting both mode lock bits together aborts.
// R15 - Password written in portions, one program command each, any order.
// R16 - Password bits only clear to zero; blank password reads all ones.
// R17 - Password reads all ones once password lock bit is programmed.
// R18 - Only two low address bits select portion; higher ones abort.
// R19 - Exact match unfreezes guard; each check takes 2 us, overlaps ignored.
// R20 - Bad unlock may enter buffer abort; host must send abort reset.
// R21 - Host tracks supplied password portions and confirms by reading freeze flag. The host tracks portions but never reads the freeze flag.
// R22 - Password set blocks array access until its exit command.
// R23 - Sector erase load window lasts 50 us, restarted by each address.
// R24 - Device models its special conditions as distinct states of one machine.
module fsl_host
  import fsl_pkg::*;
#(
  parameter int RESUME_GAP = RESUME_GAP_CYC
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // User command port
  input wire logic START_IN,
  input wire logic [3:0] OP_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic [63:0] PW_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic REFUSED_OUT,
  output logic [DATA_W-1:0] RDATA_OUT,
  output logic [1:0] MODE_OUT,
  output logic [3:0] PW_PORTIONS_OUT,
  // Flash pins
  input wire logic [DATA_W-1:0] F_DQ_IN,
  output logic [DATA_W-1:0] F_DQ_OUT,
  output logic F_DQ_OE_OUT,
  output logic [ADDR_W-1:0] F_ADDR_OUT,
  output logic F_CE_N_OUT,
  output logic F_OE_N_OUT,
  output logic F_WE_N_OUT,
  output logic F_RESET_N_OUT
);
  logic rst_n_s1_r, rst_n;
  fsl_state_type state_r;
  fsl_mode_type mode_r;
  logic [3:0] op_r;
  logic [1:0] port_r;
  logic [ADDR_W-1:0] sa [SCR_N];
  logic [DATA_W-1:0] sd [SCR_N];
  logic sr [SCR_N];
  logic [3:0] slen;
  logic [ADDR_W-1:0] scr_a_r [SCR_N];
  logic [DATA_W-1:0] scr_d_r [SCR_N];
  logic scr_r_r [SCR_N];
  logic [3:0] len_r, idx_r;
  logic cyc_start_r, cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [19:0] resume_gap_r;
  logic [7:0] unlock_gap_r;
  logic [7:0] rst_cnt_r;
  logic refuse, accept;

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_n_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_n_s1_r <= 1'b1;
      rst_n <= rst_n_s1_r;
    end
  end

  // Command refusal, checked against the tracked mode and guard timers
  always_comb begin
    refuse = 1'b0;
    case (OP_IN)
      // R12 array blocked in lock set
      // R22 array blocked in password set
      OP_READ, OP_WRITE, OP_RESUME: refuse = (mode_r != MODE_ARRAY);
      // R10 resume to suspend gap
      OP_SUSPEND: refuse = (mode_r != MODE_ARRAY) || (resume_gap_r != 20'h00000);
      OP_LOCK_ENTER, OP_PW_ENTER: refuse = (mode_r != MODE_ARRAY);
      OP_LOCK_READ: refuse = (mode_r != MODE_LOCKSET);
      // R14 both mode locks never together
      OP_LOCK_PROG: refuse = (mode_r != MODE_LOCKSET) ||
        (!DATA_IN[LOCK_PERSIST_BIT] && !DATA_IN[LOCK_PASSWORD_BIT]);
      // R18 high address bits must be zero
      OP_PW_PROG, OP_PW_READ: refuse = (mode_r != MODE_PWSET) || (ADDR_IN[ADDR_W-1:2] != '0);
      // R19 no unlock inside check window
      OP_PW_UNLOCK: refuse = (mode_r != MODE_PWSET) || (unlock_gap_r != 8'h00);
      OP_EXIT: refuse = (mode_r == MODE_ARRAY);
      OP_ABORT_RESET, OP_HW_RESET: refuse = 1'b0;
      default: refuse = 1'b1;
    endcase
  end

  assign accept = START_IN && (state_r == ST_IDLE) && !refuse;

  // Bus cycle script for each command
  always_comb begin
    for (int i = 0; i < SCR_N; i++) begin
      sa[i] = ADR_ZERO;
      sd[i] = '0;
      sr[i] = 1'b0;
    end
    slen = 4'h1;
    case (OP_IN)
      OP_READ, OP_LOCK_READ: begin
        sa[0] = (OP_IN == OP_READ) ? ADDR_IN : ADR_ZERO;
        sr[0] = 1'b1;
      end
      OP_WRITE: begin
        sa[0] = ADDR_IN;
        sd[0] = DATA_IN;
      end
      OP_SUSPEND: sd[0] = CMD_ERASE_SUSPEND;
      OP_RESUME: begin
        // R9 resume at suspended sector
        sa[0] = ADDR_IN;
        sd[0] = CMD_ERASE_RESUME;
      end
      OP_LOCK_ENTER, OP_PW_ENTER, OP_ABORT_RESET: begin
        // R20 abort reset sequence; lock and password entry share its unlock cycles
        sa[0] = ADR_UNLOCK1;
        sd[0] = CMD_UNLOCK1;
        sa[1] = ADR_UNLOCK2;
        sd[1] = CMD_UNLOCK2;
        sa[2] = ADR_UNLOCK1;
        sd[2] = (OP_IN == OP_LOCK_ENTER) ? CMD_LOCK_ENTRY :
                (OP_IN == OP_PW_ENTER) ? CMD_PW_ENTRY : CMD_ABORT_RESET;
        slen = 4'h3;
      end
      OP_LOCK_PROG: begin
        sd[0] = CMD_PROGRAM;
        sd[1] = DATA_IN;
        slen = 4'h2;
      end
      OP_PW_PROG: begin
        // R15 one program per portion
        sd[0] = CMD_PROGRAM;
        sa[1] = ADDR_IN;
        sd[1] = DATA_IN;
        slen = 4'h2;
      end
      OP_PW_READ: begin
        sa[0] = ADDR_IN;
        sr[0] = 1'b1;
      end
      OP_PW_UNLOCK: begin
        sd[0] = CMD_UNLOCK_START;
        sd[1] = CMD_UNLOCK_COUNT;
        for (int i = 0; i < 4; i++) begin
          sa[i+2] = ADDR_W'(i);
          sd[i+2] = PW_IN[16*i +: 16];
        end
        sd[6] = CMD_UNLOCK_CONFIRM;
        slen = 4'h7;
      end
      OP_EXIT: begin
        sd[0] = CMD_EXIT1;
        sd[1] = CMD_EXIT2;
        slen = 4'h2;
      end
      default: slen = 4'h1;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_r <= OP_READ;
      port_r <= 2'h0;
      len_r <= 4'h0;
      idx_r <= 4'h0;
      cyc_start_r <= 1'b0;
      rst_cnt_r <= 8'h00;
      DONE_OUT <= 1'b0;
      for (int i = 0; i < SCR_N; i++) begin
        scr_a_r[i] <= ADR_ZERO;
        scr_d_r[i] <= '0;
        scr_r_r[i] <= 1'b0;
      end
    end else begin
      DONE_OUT <= 1'b0;
      cyc_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            op_r <= OP_IN;
            port_r <= ADDR_IN[1:0];
            scr_a_r <= sa;
            scr_d_r <= sd;
            scr_r_r <= sr;
            len_r <= slen;
            idx_r <= 4'h0;
            if (OP_IN == OP_HW_RESET) begin
              rst_cnt_r <= 8'(T_RP_CYC);
              state_r <= ST_RST;
            end else begin
              cyc_start_r <= 1'b1;
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (cyc_done) begin
            if (idx_r + 4'h1 == len_r) begin
              DONE_OUT <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_r + 4'h1;
              cyc_start_r <= 1'b1;
            end
          end
        end
        ST_RST: begin
          // R13 reset pulse clears a hung device
          if (rst_cnt_r == 8'h01) begin
            DONE_OUT <= 1'b1;
            state_r <= ST_IDLE;
          end
          rst_cnt_r <= rst_cnt_r - 8'h01;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Mode and password portion tracking
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_ARRAY;
      PW_PORTIONS_OUT <= 4'h0;
    end else if (DONE_OUT) begin
      case (op_r)
        OP_LOCK_ENTER: mode_r <= MODE_LOCKSET;
        OP_PW_ENTER: mode_r <= MODE_PWSET;
        OP_EXIT, OP_HW_RESET: begin
          mode_r <= MODE_ARRAY;
          PW_PORTIONS_OUT <= 4'h0;
        end
        // R21 portions supplied so far
        OP_PW_PROG: PW_PORTIONS_OUT[port_r] <= 1'b1;
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Guard timers
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      resume_gap_r <= 20'h00000;
      unlock_gap_r <= 8'h00;
    end else begin
      // R10 start gap on resume
      if (DONE_OUT && op_r == OP_RESUME) begin
        resume_gap_r <= 20'(RESUME_GAP);
      end else if (resume_gap_r != 20'h00000) begin
        resume_gap_r <= resume_gap_r - 20'h00001;
      end
      // R19 start check window
      if (DONE_OUT && op_r == OP_PW_UNLOCK) begin
        unlock_gap_r <= 8'(UNLOCK_GAP_CYC);
      end else if (unlock_gap_r != 8'h00) begin
        unlock_gap_r <= unlock_gap_r - 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      REFUSED_OUT <= 1'b0;
      RDATA_OUT <= '0;
    end else begin
      REFUSED_OUT <= START_IN && (state_r == ST_IDLE) && refuse;
      if (cyc_done && scr_r_r[idx_r[2:0]]) begin
        RDATA_OUT <= cyc_rdata;
      end
    end
  end

  fsl_cycle u_cycle (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .start_in(cyc_start_r),
    .rd_in(scr_r_r[idx_r[2:0]]),
    .addr_in(scr_a_r[idx_r[2:0]]),
    .wdata_in(scr_d_r[idx_r[2:0]]),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .dq_in(F_DQ_IN),
    .addr_out(F_ADDR_OUT),
    .dq_out(F_DQ_OUT),
    .dq_oe_out(F_DQ_OE_OUT),
    .ce_n_out(F_CE_N_OUT),
    .oe_n_out(F_OE_N_OUT),
    .we_n_out(F_WE_N_OUT)
  );

  assign F_RESET_N_OUT = (state_r != ST_RST);
  assign BUSY_OUT = (state_r != ST_IDLE);
  assign MODE_OUT = mode_r;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  sequence s_req(logic [3:0] op);
    START_IN && (state_r == ST_IDLE) && (OP_IN == op);
  endsequence

  property p_array_blocked;
    (s_req(OP_READ) or s_req(OP_WRITE)) ##0 (mode_r != MODE_ARRAY) |=> REFUSED_OUT;
  endproperty
  a_array_blocked: assert property (p_array_blocked) else $error("array op not refused"); // R12

  property p_pw_blocked;
    s_req(OP_READ) ##0 (mode_r == MODE_PWSET) |=> REFUSED_OUT && !BUSY_OUT;
  endproperty
  a_pw_blocked: assert property (p_pw_blocked) else $error("read in password set"); // R22

  property p_susp_gap;
    s_req(OP_SUSPEND) ##0 (resume_gap_r != 20'h00000) |=> REFUSED_OUT && !BUSY_OUT;
  endproperty
  a_susp_gap: assert property (p_susp_gap) else $error("suspend inside gap"); // R10

  property p_gap_load;
    DONE_OUT && (op_r == OP_RESUME) |=> resume_gap_r == 20'(RESUME_GAP);
  endproperty
  a_gap_load: assert property (p_gap_load) else $error("resume gap not armed"); // R10

  property p_both_locks;
    s_req(OP_LOCK_PROG) ##0 (DATA_IN[2:1] == 2'b00) |=> REFUSED_OUT;
  endproperty
  a_both_locks: assert property (p_both_locks) else $error("both locks programmed"); // R14

  property p_pw_addr;
    s_req(OP_PW_PROG) ##0 (ADDR_IN[ADDR_W-1:2] != '0) |=> REFUSED_OUT && !BUSY_OUT;
  endproperty
  a_pw_addr: assert property (p_pw_addr) else $error("high password address"); // R18

  property p_unlock_gap;
    DONE_OUT && (op_r == OP_PW_UNLOCK) ##1 s_req(OP_PW_UNLOCK) |=> REFUSED_OUT;
  endproperty
  a_unlock_gap: assert property (p_unlock_gap) else $error("unlock inside window"); // R19

  property p_hw_reset;
    s_req(OP_HW_RESET) |=> !F_RESET_N_OUT [*8];
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("reset pulse too short"); // R13

  property p_resume_addr;
    (state_r == ST_RUN) && (op_r == OP_RESUME) && !F_WE_N_OUT |->
      (F_ADDR_OUT == scr_a_r[0]) && (F_DQ_OUT == CMD_ERASE_RESUME);
  endproperty
  a_resume_addr: assert property (p_resume_addr) else $error("resume address wrong"); // R9

  property p_exit_mode;
    DONE_OUT && (op_r == OP_EXIT) |=> MODE_OUT == MODE_ARRAY;
  endproperty
  a_exit_mode: assert property (p_exit_mode) else $error("exit kept set mode"); // R22
endmodule

// ===== verif/fsl_flash_model.sv
module fsl_flash_model
  import fsl_pkg::*;
(
  // Flash pins
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic reset_n_in,
  output logic [DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  fsl_mode_type mode = MODE_ARRAY;
  logic [DATA_W-1:0] lock_reg = 16'hFFFF;
  logic [DATA_W-1:0] pw [4] = '{default: 16'hFFFF};
  logic [DATA_W-1:0] unl_w [4] = '{default: 16'h0000};
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] rd_word = 16'h0000;
  logic prog_pend = 1'b0;
  logic exit_pend = 1'b0;
  logic suspended = 1'b0;
  logic freeze = 1'b1;
  localparam int SECT_LSB = 16;
  localparam logic [DATA_W-1:0] ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] STAT_SUSP = 16'h0080;
  localparam logic [DATA_W-1:0] STAT_BUSY = 16'h0000;
  logic erase_on = 1'b0;
  logic erase_setup = 1'b0;
  logic [ADDR_W-1:SECT_LSB] erase_sec = '0;
  logic drv;
  int unl_cnt = 0;

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
    if (mode == MODE_LOCKSET) return lock_reg;
    if (mode == MODE_PWSET) begin
      if (!lock_reg[LOCK_PASSWORD_BIT] || a[ADDR_W-1:2] != '0) return 16'hFFFF;
      return pw[a[1:0]];
    end
    // status instead of data inside the erase
    if (erase_on && (!suspended || a[ADDR_W-1:SECT_LSB] == erase_sec)) begin
      return suspended ? STAT_SUSP : STAT_BUSY;
    end
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  always @(posedge we_n_in) begin
    if (!ce_n_in && reset_n_in) begin
      if (prog_pend) begin
        prog_pend = 1'b0;
        case (mode)
          MODE_ARRAY: mem[addr_in] = read_word(addr_in) & dq_in;
          MODE_PWSET: if (addr_in[ADDR_W-1:2] == '0) pw[addr_in[1:0]] &= dq_in;
          default: if (dq_in[2:1] != 2'b00) lock_reg &= dq_in;
        endcase
      end else if (unl_cnt == 1) begin
        unl_cnt = 2;
      end else if (unl_cnt > 1 && unl_cnt < 6) begin
        unl_w[addr_in[1:0]] = dq_in;
        unl_cnt++;
      end else if (unl_cnt == 6) begin
        if (dq_in == CMD_UNLOCK_CONFIRM && unl_w == pw) freeze = 1'b0;
        unl_cnt = 0;
      end else begin
        // command decode, sequences taken in the suspended state too
        case (dq_in)
          ERASE_SETUP: erase_setup = 1'b1;
          CMD_PROGRAM: prog_pend = 1'b1;
          CMD_LOCK_ENTRY: mode = MODE_LOCKSET;
          CMD_PW_ENTRY: mode = MODE_PWSET;
          CMD_EXIT1: exit_pend = 1'b1;
          CMD_EXIT2: if (exit_pend) mode = MODE_ARRAY;
          // suspend only while a sector erase runs, taken at once
          CMD_ERASE_SUSPEND: if (erase_on) suspended = 1'b1;
          // erase starts; resume at the sector ends it, repeats do nothing
          CMD_ERASE_RESUME: begin
            if (erase_setup) begin
              erase_on = 1'b1;
              erase_sec = addr_in[ADDR_W-1:SECT_LSB];
            end else if (suspended && addr_in[ADDR_W-1:SECT_LSB] == erase_sec) begin
              suspended = 1'b0;
              erase_on = 1'b0;
            end
          end
          CMD_UNLOCK_START: if (mode == MODE_PWSET) unl_cnt = 1;
          default: ;
        endcase
        if (dq_in == CMD_EXIT2) exit_pend = 1'b0;
        if (dq_in != CMD_UNLOCK1 && dq_in != CMD_UNLOCK2 && dq_in != ERASE_SETUP) begin
          erase_setup = 1'b0;
        end
      end
    end
  end

  // reset leaves lock bits and password
  always @(negedge reset_n_in) begin
    mode = MODE_ARRAY;
    prog_pend = 1'b0;
    exit_pend = 1'b0;
    unl_cnt = 0;
    suspended = 1'b0;
    erase_on = 1'b0;
    erase_setup = 1'b0;
  end

  // Released bus shows the inverse of the last word
  assign drv = !ce_n_in && !oe_n_in && reset_n_in;
  always @(drv or addr_in) if (drv) rd_word = read_word(addr_in);
  assign dq_out = drv ? rd_word : ~rd_word;
endmodule

// ===== verif/test_fsl_host.sv
module test_fsl_host
  import fsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [3:0] op = 4'h0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] data = '0;
  logic [63:0] pw = '0;
  logic busy, done, refused, dq_oe, ce_n, oe_n, we_n, frst_n;
  logic [DATA_W-1:0] rdata, dq_o, dq_m, dq_bus;
  logic [1:0] mode;
  logic [3:0] portions;
  logic [ADDR_W-1:0] f_addr;
  logic seen_rst = 1'b0;
  int errors = 0;
  int n_compared = 0;

  always #5 clk = ~clk;
  assign dq_bus = dq_oe ? dq_o : dq_m;
  always @(negedge frst_n) seen_rst = 1'b1;

  fsl_host #(.RESUME_GAP(GAP)) dut_u (.CLK_IN(clk), .RESETN_IN(rst_n), .START_IN(start),
    .OP_IN(op), .ADDR_IN(addr), .DATA_IN(data), .PW_IN(pw), .BUSY_OUT(busy),
    .DONE_OUT(done), .REFUSED_OUT(refused), .RDATA_OUT(rdata), .MODE_OUT(mode),
    .PW_PORTIONS_OUT(portions), .F_DQ_IN(dq_bus), .F_DQ_OUT(dq_o), .F_DQ_OE_OUT(dq_oe),
    .F_ADDR_OUT(f_addr), .F_CE_N_OUT(ce_n), .F_OE_N_OUT(oe_n), .F_WE_N_OUT(we_n),
    .F_RESET_N_OUT(frst_n));

  fsl_flash_model flash_u (.addr_in(f_addr), .dq_in(dq_o), .ce_n_in(ce_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .reset_n_in(frst_n), .dq_out(dq_m));

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, errors %0d", name, errors);
  endtask

  task automatic do_op(input logic [3:0] o, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic exp_ref);
    int i;
    op = o;
    addr = a;
    data = d;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    for (i = 0; i < 3000; i++) begin
      if (done === 1'b1 || refused === 1'b1) break;
      @(posedge clk);
      #1;
    end
    if (i == 3000) begin
      errors++;
      $display("Error op %h expected done seen timeout", o);
      finish_test();
    end
    chk("refused", 16'(exp_ref), 16'(refused));
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [15:0] e);
    do_op(o, a, '0, 1'b0);
    chk("rdata", e, rdata);
  endtask

  task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    do_op(OP_WRITE, ADR_UNLOCK1, CMD_PROGRAM, 1'b0);
    do_op(OP_WRITE, a, d, 1'b0);
  endtask

  task automatic erase_sec(input logic [ADDR_W-1:0] sa);
    do_op(OP_WRITE, ADR_UNLOCK1, CMD_UNLOCK1, 1'b0);
    do_op(OP_WRITE, ADR_UNLOCK2, CMD_UNLOCK2, 1'b0);
    do_op(OP_WRITE, ADR_UNLOCK1, 16'h0080, 1'b0);
    do_op(OP_WRITE, ADR_UNLOCK1, CMD_UNLOCK1, 1'b0);
    do_op(OP_WRITE, ADR_UNLOCK2, CMD_UNLOCK2, 1'b0);
    do_op(OP_WRITE, sa, CMD_ERASE_RESUME, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    chk("busy", 16'h0000, 16'(busy));
    chk("ce_n", 16'h0001, 16'(ce_n));
    chk("dq_oe", 16'h0000, 16'(dq_oe));
    chk("reset_pin", 16'h0001, 16'(frst_n));
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    end_test("reset");
    prog(25'h0001000, 16'h5A3C);
    rd(OP_READ, 25'h0001000, 16'h5A3C);
    do_op(4'hE, '0, '0, 1'b1);
    do_op(OP_EXIT, '0, '0, 1'b1);
    do_op(OP_LOCK_READ, '0, '0, 1'b1);
    do_op(OP_PW_READ, '0, '0, 1'b1);
    end_test("array");
    erase_sec(25'h0010000);
    do_op(OP_SUSPEND, '0, '0, 1'b0);
    rd(OP_READ, 25'h0010000, 16'h0080);
    prog(25'h0002000, 16'h1357);
    rd(OP_READ, 25'h0002000, 16'h1357);
    rd(OP_READ, 25'h0010000, 16'h0080);
    rd(OP_READ, 25'h0001000, 16'h5A3C);
    do_op(OP_RESUME, 25'h0010000, '0, 1'b0);
    do_op(OP_SUSPEND, '0, '0, 1'b1);
    rd(OP_READ, 25'h0010000, 16'hFFFF);
    repeat (GAP) @(posedge clk);
    #1;
    do_op(OP_SUSPEND, '0, '0, 1'b0);
    rd(OP_READ, 25'h0001000, 16'h5A3C);
    do_op(OP_RESUME, 25'h0010000, '0, 1'b0);
    end_test("suspend");
    do_op(OP_LOCK_ENTER, '0, '0, 1'b0);
    chk("mode", 16'(MODE_LOCKSET), 16'(mode));
    do_op(OP_READ, 25'h0001000, '0, 1'b1);
    do_op(OP_WRITE, 25'h0001000, '0, 1'b1);
    rd(OP_LOCK_READ, '0, 16'hFFFF);
    do_op(OP_LOCK_PROG, '0, 16'hFFF9, 1'b1);
    do_op(OP_LOCK_PROG, '0, 16'hFFFE, 1'b0);
    rd(OP_LOCK_READ, '0, 16'hFFFE);
    do_op(OP_PW_ENTER, '0, '0, 1'b1);
    do_op(OP_EXIT, '0, '0, 1'b0);
    chk("mode", 16'(MODE_ARRAY), 16'(mode));
    rd(OP_READ, 25'h0001000, 16'h5A3C);
    end_test("lockset");
    do_op(OP_PW_ENTER, '0, '0, 1'b0);
    chk("mode", 16'(MODE_PWSET), 16'(mode));
    do_op(OP_READ, 25'h0001000, '0, 1'b1);
    rd(OP_PW_READ, 25'h0000003, 16'hFFFF);
    do_op(OP_PW_PROG, 25'h0000002, 16'h1234, 1'b0);
    do_op(OP_PW_PROG, 25'h0000000, 16'hABCD, 1'b0);
    do_op(OP_PW_PROG, 25'h0000002, 16'hFFFF, 1'b0);
    rd(OP_PW_READ, 25'h0000002, 16'h1234);
    rd(OP_PW_READ, 25'h0000000, 16'hABCD);
    do_op(OP_PW_PROG, 25'h0000004, 16'h0000, 1'b1);
    do_op(OP_PW_READ, 25'h0000004, '0, 1'b1);
    chk("portions", 16'h0005, 16'(portions));
    pw = 64'hFFFF_1234_FFFF_ABCD;
    do_op(OP_PW_UNLOCK, '0, '0, 1'b0);
    do_op(OP_PW_UNLOCK, '0, '0, 1'b1);
    do_op(OP_ABORT_RESET, '0, '0, 1'b0);
    chk("mode", 16'(MODE_PWSET), 16'(mode));
    do_op(OP_EXIT, '0, '0, 1'b0);
    chk("mode", 16'(MODE_ARRAY), 16'(mode));
    end_test("password");
    do_op(OP_LOCK_ENTER, '0, '0, 1'b0);
    do_op(OP_HW_RESET, '0, '0, 1'b0);
    chk("reset_pulse", 16'h0001, 16'(seen_rst));
    chk("mode", 16'(MODE_ARRAY), 16'(mode));
    rd(OP_READ, 25'h0001000, 16'h5A3C);
    do_op(OP_LOCK_ENTER, '0, '0, 1'b0);
    rd(OP_LOCK_READ, '0, 16'hFFFE);
    do_op(OP_LOCK_PROG, '0, 16'hFFFB, 1'b0);
    do_op(OP_EXIT, '0, '0, 1'b0);
    do_op(OP_PW_ENTER, '0, '0, 1'b0);
    rd(OP_PW_READ, 25'h0000002, 16'hFFFF);
    do_op(OP_EXIT, '0, '0, 1'b0);
    end_test("hang");
    finish_test();
  end
endmodule
